// ### design/tcb_config_bank.v
// Threshold and edge-interrupt selection register bank with crossing detectors
`timescale 1ns/1ps
`include "tcb_defines.vh"
// How it works
// - Input 23 selection: 10 bits at 15:6, five 2-bit selectors.
// - Selector 00: never an event for that input and threshold.
// - Selector 01: event only when value rises above threshold.
// - Selector 10: event only when value falls to or below threshold.
// - Selector 11: event on crossing in either direction.
// - Input 23 bits 1:0 to group-3 slot A, bits 3:2 to slot B.
// - Input 23 bits 5:4 to slot C, bits 7:6 to threshold 8.
// - Input 23 bits 9:8 to threshold 9, same encoding.
// - Input 22 selection at bits 5:0: slots A, B, C low to high.
// - Both selection fields reset to zero: no events until configured.
// - Threshold 0 at bits 9:0 of first threshold register.
// - Threshold 1 at bits 19:10 of first threshold register.
// - Threshold 2 at bits 9:0 of second threshold register.
// - Threshold 3 at bits 19:10 of second; bits 23:20 reserved.
// - Threshold 4 at bits 9:0 of third threshold register.
// - Threshold 5 at bits 19:10 of third; all thresholds reset zero.

module tcb_config_bank #(
   parameter LIM_W = 10
) (
   input  wire                     clock,               // System clock, 50 MHz
   input  wire                     reset,               // Asynchronous reset, active high
   input  wire                     reg_wr,              // Register write strobe
   input  wire                     reg_rd,              // Register read strobe
   input  wire [`TCB_ADDR_W-1:0]   reg_addr,            // Register offset
   input  wire [`TCB_DATA_W-1:0]   reg_wdata,           // Write data
   output reg  [`TCB_DATA_W-1:0]   reg_rdata,           // Read data, valid after reg_rd
   output reg                      reg_rvalid,          // Read data valid pulse
   input  wire                     sample_vld,          // New samples this cycle
   input  wire [LIM_W-1:0]         switch_input_22,     // Measured value of input 22
   input  wire [LIM_W-1:0]         switch_input_23,     // Measured value of input 23
   input  wire [LIM_W-1:0]         group3_limit_slot_a, // Group-3 threshold slot A
   input  wire [LIM_W-1:0]         group3_limit_slot_b, // Group-3 threshold slot B
   input  wire [LIM_W-1:0]         group3_limit_slot_c, // Group-3 threshold slot C
   input  wire [LIM_W-1:0]         level_limit_eight,   // Threshold 8
   input  wire [LIM_W-1:0]         level_limit_nine,    // Threshold 9
   output reg  [LIM_W-1:0]         level_limit_zero,    // Threshold 0
   output reg  [LIM_W-1:0]         level_limit_one,     // Threshold 1
   output reg  [LIM_W-1:0]         level_limit_two,     // Threshold 2
   output reg  [LIM_W-1:0]         level_limit_three,   // Threshold 3
   output reg  [LIM_W-1:0]         level_limit_four,    // Threshold 4
   output reg  [LIM_W-1:0]         level_limit_five,    // Threshold 5
   output reg  [2:0]               event_ch22,          // Crossing events input 22, A..C
   output reg  [4:0]               event_ch23           // Crossing events input 23, A,B,C,8,9
);

   // =====================================================================
   // Register storage
   reg  [`TCB_DATA_W-1:0] level_limits_0_1_reg;
   reg  [`TCB_DATA_W-1:0] level_limits_2_3_reg;
   reg  [`TCB_DATA_W-1:0] level_limits_4_5_reg;
   reg  [`TCB_DATA_W-1:0] edge_irq_select_bank_four_reg;
   reg  [`TCB_DATA_W-1:0] rdata_next;
   wire [5:0]             edge_irq_sel_ch22;
   wire [9:0]             edge_irq_sel_ch23;
   wire [2:0]             ev22;
   wire [4:0]             ev23;
   wire [5*LIM_W-1:0]     lim23;

   assign edge_irq_sel_ch22 = edge_irq_select_bank_four_reg[`TCB_SEL22_MSB:`TCB_SEL22_LSB];
   assign edge_irq_sel_ch23 = edge_irq_select_bank_four_reg[`TCB_SEL23_MSB:`TCB_SEL23_LSB];

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         level_limits_0_1_reg          <= `TCB_RESET_VALUE;
         level_limits_2_3_reg          <= `TCB_RESET_VALUE;
         level_limits_4_5_reg          <= `TCB_RESET_VALUE;
         edge_irq_select_bank_four_reg <= `TCB_RESET_VALUE;
      end else if (reg_wr) begin
         // Unused upper bits are masked on write so they always read zero
         case (reg_addr)
            `TCB_OFF_LIMITS_0_1: level_limits_0_1_reg <= reg_wdata & `TCB_LIM_USED_MASK;
            `TCB_OFF_LIMITS_2_3: level_limits_2_3_reg <= reg_wdata & `TCB_LIM_USED_MASK;
            `TCB_OFF_LIMITS_4_5: level_limits_4_5_reg <= reg_wdata & `TCB_LIM_USED_MASK;
            `TCB_OFF_EDGE_SEL:
               edge_irq_select_bank_four_reg <= reg_wdata & `TCB_SEL_USED_MASK;
            default: ;
         endcase
      end
   end

   // =====================================================================
   // Read path: unmapped offsets read zero
   always @* begin
      case (reg_addr)
         `TCB_OFF_LIMITS_0_1: rdata_next = level_limits_0_1_reg;
         `TCB_OFF_LIMITS_2_3: rdata_next = level_limits_2_3_reg;
         `TCB_OFF_LIMITS_4_5: rdata_next = level_limits_4_5_reg;
         `TCB_OFF_EDGE_SEL:   rdata_next = edge_irq_select_bank_four_reg;
         default:             rdata_next = `TCB_RESET_VALUE;
      endcase
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata  <= `TCB_RESET_VALUE;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_next;
         end
      end
   end

   // =====================================================================
   // Threshold fields, registered so each output comes from a flip-flop
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         level_limit_zero  <= {LIM_W{1'b0}};
         level_limit_one   <= {LIM_W{1'b0}};
         level_limit_two   <= {LIM_W{1'b0}};
         level_limit_three <= {LIM_W{1'b0}};
         level_limit_four  <= {LIM_W{1'b0}};
         level_limit_five  <= {LIM_W{1'b0}};
      end else begin
         level_limit_zero  <= level_limits_0_1_reg[`TCB_LIM_LO_MSB:`TCB_LIM_LO_LSB];
         level_limit_one   <= level_limits_0_1_reg[`TCB_LIM_HI_MSB:`TCB_LIM_HI_LSB];
         level_limit_two   <= level_limits_2_3_reg[`TCB_LIM_LO_MSB:`TCB_LIM_LO_LSB];
         level_limit_three <= level_limits_2_3_reg[`TCB_LIM_HI_MSB:`TCB_LIM_HI_LSB];
         level_limit_four  <= level_limits_4_5_reg[`TCB_LIM_LO_MSB:`TCB_LIM_LO_LSB];
         level_limit_five  <= level_limits_4_5_reg[`TCB_LIM_HI_MSB:`TCB_LIM_HI_LSB];
      end
   end

   // =====================================================================
   // Crossing detectors: input 22 against slots A..C
   assign lim23 = {level_limit_nine, level_limit_eight,
                   group3_limit_slot_c, group3_limit_slot_b, group3_limit_slot_a};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch22
         tcb_edge_detect #(.LIM_W(LIM_W)) u_det (
            .clock      (clock),
            .reset      (reset),
            .sample_vld (sample_vld),
            .sample     (switch_input_22),
            .limit      (lim23[gi*LIM_W +: LIM_W]),
            .sel        (edge_irq_sel_ch22[2*gi +: 2]),
            .event_out  (ev22[gi])
         );
      end
      // Input 23 against A, B (bits 3:0), C, eight (7:4), nine (9:8)
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_ch23
         tcb_edge_detect #(.LIM_W(LIM_W)) u_det (
            .clock      (clock),
            .reset      (reset),
            .sample_vld (sample_vld),
            .sample     (switch_input_23),
            .limit      (lim23[gi*LIM_W +: LIM_W]),
            .sel        (edge_irq_sel_ch23[2*gi +: 2]),
            .event_out  (ev23[gi])
         );
      end
   endgenerate

   // Detector outputs are flops already; one more stage keeps the top outputs aligned
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         event_ch22 <= 3'h0;
         event_ch23 <= 5'h00;
      end else begin
         event_ch22 <= ev22;
         event_ch23 <= ev23;
      end
   end

endmodule

// ### design/tcb_defines.vh
// Register offsets, field positions and reset values of the threshold configuration bank
`ifndef TCB_DEFINES_VH
`define TCB_DEFINES_VH

`define TCB_ADDR_W          6
`define TCB_DATA_W          24
`define TCB_LIM_W           10
`define TCB_SEL_W           2

`define TCB_OFF_LIMITS_0_1  6'h29
`define TCB_OFF_LIMITS_2_3  6'h2A
`define TCB_OFF_LIMITS_4_5  6'h2B
`define TCB_OFF_EDGE_SEL    6'h28

`define TCB_LIM_LO_LSB      0
`define TCB_LIM_LO_MSB      9
`define TCB_LIM_HI_LSB      10
`define TCB_LIM_HI_MSB      19
`define TCB_LIM_USED_MASK   24'h0FFFFF

`define TCB_SEL22_LSB       0
`define TCB_SEL22_MSB       5
`define TCB_SEL23_LSB       6
`define TCB_SEL23_MSB       15
`define TCB_SEL_USED_MASK   24'h00FFFF

`define TCB_RESET_VALUE     24'h000000

`define TCB_SEL_NONE        2'h0
`define TCB_SEL_RISE        2'h1
`define TCB_SEL_FALL        2'h2
`define TCB_SEL_BOTH        2'h3

`endif

// ### design/tcb_edge_detect.v
// One crossing detector: input sample against one limit, gated by a 2-bit selector
`timescale 1ns/1ps
`include "tcb_defines.vh"

module tcb_edge_detect #(
   parameter LIM_W = 10
) (
   input  wire             clock,      // System clock
   input  wire             reset,      // Asynchronous reset, active high
   input  wire             sample_vld, // New sample present this cycle
   input  wire [LIM_W-1:0] sample,     // Measured value
   input  wire [LIM_W-1:0] limit,      // Threshold
   input  wire [1:0]       sel,        // Edge selector
   output reg              event_out   // One-cycle crossing event
);

   reg  above_reg;
   reg  primed_reg;
   wire above_now;
   wire rise;
   wire fall;

   assign above_now = (sample > limit);
   // First sample after reset only primes the history, so no false edge
   assign rise = primed_reg & ~above_reg & above_now;
   assign fall = primed_reg & above_reg & ~above_now;

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         above_reg  <= 1'b0;
         primed_reg <= 1'b0;
         event_out  <= 1'b0;
      end else begin
         event_out <= 1'b0;
         if (sample_vld) begin
            above_reg  <= above_now;
            primed_reg <= 1'b1;
            case (sel)
               `TCB_SEL_NONE: event_out <= 1'b0;
               `TCB_SEL_RISE: event_out <= rise;
               `TCB_SEL_FALL: event_out <= fall;
               `TCB_SEL_BOTH: event_out <= rise | fall;
               default:       event_out <= 1'b0;
            endcase
         end
      end
   end

endmodule

// ### verification/tcb_config_bank_asserts.sv
// Port checker for the threshold configuration bank
`timescale 1ns/1ps
`include "tcb_defines.vh"
module tcb_config_bank_asserts #(parameter LIM_W = 10) (
   input wire logic             clock,           // Clock
   input wire logic             reset,           // Reset
   input wire logic             reg_wr,          // Write
   input wire logic             reg_rd,          // Read
   input wire logic [5:0]       reg_addr,        // Offset
   input wire logic [23:0]      reg_wdata,       // Write data
   input wire logic [23:0]      reg_rdata,       // Read data
   input wire logic             reg_rvalid,      // Read data valid
   input wire logic             sample_vld,      // Sample strobe
   input wire logic [2:0]       event_ch22,      // Events 22
   input wire logic [4:0]       event_ch23,      // Events 23
   input wire logic [LIM_W-1:0] level_limit_zero // Threshold 0
);
   // ====================
   // Selector mirror, rebuilt from host writes since the bank hides its flops
   logic [15:0] sel_m;
   always @(posedge clock or posedge reset) begin
      if (reset)
         sel_m <= 16'h0000;
      else if (reg_wr && reg_addr == `TCB_OFF_EDGE_SEL)
         sel_m <= reg_wdata[15:0];
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sel_read_a: assert property (
      reg_rd && reg_addr == `TCB_OFF_EDGE_SEL |=> reg_rdata == {8'h00, $past(sel_m)})
      else $error("select readback wrong");
   read_valid_a: assert property (reg_rvalid == $past(reg_rd))
      else $error("read valid pulse wrong");
   limit_resv_a: assert property (
      reg_rd && reg_addr[5:2] == 4'hA && reg_addr[1:0] != 2'h0 |=> reg_rdata[23:20] == 4'h0)
      else $error("reserved limit bits set");
   limit_zero_a: assert property (
      reg_wr && reg_addr == `TCB_OFF_LIMITS_0_1 ##1 !reg_wr |=>
      level_limit_zero == $past(reg_wdata[9:0], 2))
      else $error("threshold 0 not taken");
   event_cause_a: assert property (
      (|event_ch22 || |event_ch23) |-> $past(sample_vld, 2))
      else $error("event without sample");
   slot_a_quiet_a: assert property ((sel_m[7:6] == 2'h0) [*3] |-> !event_ch23[0])
      else $error("slot A event while off");
   eight_quiet_a: assert property ((sel_m[13:12] == 2'h0) [*3] |-> !event_ch23[3])
      else $error("threshold 8 event while off");
   nine_quiet_a: assert property ((sel_m[15:14] == 2'h0) [*3] |-> !event_ch23[4])
      else $error("threshold 9 event while off");
   ch22_quiet_a: assert property ((sel_m[5:4] == 2'h0) [*3] |-> !event_ch22[2])
      else $error("input 22 slot C event while off");
endmodule
bind tcb_config_bank tcb_config_bank_asserts #(.LIM_W(LIM_W)) tcb_config_bank_asserts_inst (.*);

// ### verification/tcb_host_model.sv
// Host model that issues register writes and reads to the bank
`timescale 1ns/1ps
module tcb_host_model (
   input  wire logic        clock,     // Clock
   output logic             reg_wr,    // Write
   output logic             reg_rd,    // Read
   output logic [5:0]       reg_addr,  // Offset
   output logic [23:0]      reg_wdata, // Write data
   input  wire logic [23:0] reg_rdata  // Read data
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 24'h000000;
   end
   // ====================
   // Released lines show the inverse so stale values are never trusted
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [23:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

// ### verification/test_threshold_irq_config_bank.sv
// Self-checking bench for the threshold configuration bank
`timescale 1ns/1ps
`include "tcb_defines.vh"
module test_threshold_irq_config_bank;
   logic        clock, reset, sample_vld, reg_wr, reg_rd;
   logic [5:0]  reg_addr;
   logic [23:0] reg_wdata, reg_rdata, got;
   logic [23:0] w [4];
   logic [9:0]  lim, smp;
   logic [9:0]  lm [6];
   logic [2:0]  ev22;
   logic [4:0]  ev23;
   logic [15:0] sel;
   logic [31:0] r;
   logic [31:0] seed = 32'h7A6D;
   int          n_mismatch = 0;
   int          n_tests = 0;
   tcb_host_model tcb_host_model_inst (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   tcb_config_bank #(.LIM_W(10)) tcb_config_bank_inst (.clock(clock), .reset(reset),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(), .sample_vld(sample_vld),
      .switch_input_22(smp), .switch_input_23(smp), .group3_limit_slot_a(lim),
      .group3_limit_slot_b(lim), .group3_limit_slot_c(lim), .level_limit_eight(lim),
      .level_limit_nine(lim), .level_limit_zero(lm[0]), .level_limit_one(lm[1]),
      .level_limit_two(lm[2]), .level_limit_three(lm[3]), .level_limit_four(lm[4]),
      .level_limit_five(lm[5]), .event_ch22(ev22), .event_ch23(ev23));
   // ====================
   // Helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] edge_exp(input logic [15:0] s, input logic up);
      for (int i = 0; i < 8; i++)
         edge_exp[i] = up ? s[2*i] : s[2*i+1];
   endfunction
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Sample lines are inverted while not valid so ignored cycles would cause crossings
   task automatic step(input logic [9:0] v, input logic [7:0] ex);
      @(negedge clock);
      smp = v;
      sample_vld = 1'b1;
      @(negedge clock);
      sample_vld = 1'b0;
      smp = ~v;
      // Events are one-cycle pulses two flops deep, so look on the second falling edge after the sample is driven
      @(negedge clock);
      check("event_ch22", {21'h0, ev22}, {21'h0, ex[2:0]});
      check("event_ch23", {19'h0, ev23}, {19'h0, ex[7:3]});
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      #100000;
      n_mismatch++;
      close_out();
   end
   initial begin
      reset = 1'b1;
      sample_vld = 1'b0;
      smp = 10'h000;
      lim = 10'h000;
      repeat (3) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      for (logic [5:0] a = 6'h28; a < 6'h2C; a++) begin
         tcb_host_model_inst.rd(a, got);
         check("reset value", got, 24'h000000);
      end
      for (int p = 0; p < 2; p++) begin
         for (int k = 1; k < 4; k++) begin
            r = xs();
            w[k] = p ? r[23:0] : 24'hFFFFFF;
            tcb_host_model_inst.wr(6'h28 + 6'(k), w[k]);
         end
         for (int k = 1; k < 4; k++) begin
            tcb_host_model_inst.rd(6'h28 + 6'(k), got);
            check("limit register", got, w[k] & `TCB_LIM_USED_MASK);
            check("limit outputs", {4'h0, lm[2*k-1], lm[2*k-2]}, w[k] & `TCB_LIM_USED_MASK);
         end
      end
      tcb_host_model_inst.wr(6'h2C, 24'hABCDEF);
      tcb_host_model_inst.rd(6'h2C, got);
      check("unmapped read", got, 24'h000000);
      r = xs();
      lim = {1'b0, r[8:0]} | 10'h001;
      for (int it = 0; it < 12; it++) begin
         r = xs();
         sel = (it < 4) ? {8{it[1:0]}} : r[15:0];
         tcb_host_model_inst.wr(`TCB_OFF_EDGE_SEL, {r[31:24], sel});
         tcb_host_model_inst.rd(`TCB_OFF_EDGE_SEL, got);
         check("select register", got, {8'h00, sel});
         step(lim, 8'h00);
         step(lim + 10'h001, edge_exp(sel, 1'b1));
         step(lim, edge_exp(sel, 1'b0));
      end
      close_out();
   end
endmodule
